// ==== design/converter_startup_control.sv ====
// start/stop sequencer for a boost stage followed by an inverter
// What this block does
// R1: after power-up initialise, then wait idle for a start request
// R2: start press while idle enables boost first, inverter only afterwards
// R3: enter running state only once inverter startup has completed
// R4: stop press halts boost and inverter, then return to idle
// R5: each frequency-toggle press while idle flips output frequency between 50 and 60 Hz
// R6: output frequency defaults to 60 Hz at startup
// R7: operator toggles frequency only while neither stage is driven
// R8: voltage switch off selects high voltages, on selects low voltages
// R9: boot-mode DIP must be on, off, off for single-chip operation
// R10: reset button applies power-on reset, returning controller to initial state
// R11: inverter held stopped during boost soft start, enabled after it
// R12: buttons debounced, one event per press; stop beats simultaneous start
`timescale 1ns/100ps
module converter_startup_control import startup_pkg::*; (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       runRequestButton,
	input  wire logic       haltRequestButton,
	input  wire logic       freqToggleButton,
	input  wire logic       cpuResetButton,
	input  wire logic       voltageRangeDip,
	input  wire logic [2:0] cpuBootModeDip,
	input  wire logic       softStartDone,
	input  wire logic       inverterStartDone,
	output logic            boostEnable,
	output logic            inverterEnable,
	output logic            running,
	output logic            idle,
	output logic            freqSelect60,
	output logic            highVoltageSel,
	output logic            cpuResetOut,
	output logic            bootModeOk
);

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	typedef struct packed {
		logic [3:0]       sync1;
		logic [3:0]       sync2;
		logic [3:0]       stable;
		logic [3:0]       prev;
		logic [4*CNT_W-1:0] dbCnt;
		logic [1:0]       doneS1;
		logic [1:0]       doneS2;
		logic             voltS1;
		logic             voltS2;
		logic [2:0]       bootS1;
		logic [2:0]       bootS2;
		seq_state_e       state;
		logic [CNT_W-1:0] initCnt;
		logic [CNT_W-1:0] rstCnt;
		logic             boostEn;
		logic             invEn;
		logic             run;
		logic             idl;
		logic             freq;
		logic             highV;
		logic             cpuRst;
		logic             bootOk;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;
	logic [3:0] press;

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// every pin except clock and rst passes two flops before use
		st_nxt.sync1  = {cpuResetButton, freqToggleButton, haltRequestButton, runRequestButton};
		st_nxt.sync2  = st_r.sync1;
		st_nxt.doneS1 = {inverterStartDone, softStartDone};
		st_nxt.doneS2 = st_r.doneS1;
		st_nxt.voltS1 = voltageRangeDip;
		st_nxt.voltS2 = st_r.voltS1;
		st_nxt.bootS1 = cpuBootModeDip;
		st_nxt.bootS2 = st_r.bootS1;
		st_nxt.prev   = st_r.stable;
		for (int i = 0; i < 4; i++) begin
			// accept a new level only after it held for the full window
			if (st_r.sync2[i] == st_r.stable[i]) begin
				st_nxt.dbCnt[i*CNT_W +: CNT_W] = CNT_ZERO; // R12
			end else if (st_r.dbCnt[i*CNT_W +: CNT_W] == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
				st_nxt.stable[i] = st_r.sync2[i]; // R12
				st_nxt.dbCnt[i*CNT_W +: CNT_W] = CNT_ZERO;
			end else begin
				st_nxt.dbCnt[i*CNT_W +: CNT_W] = st_r.dbCnt[i*CNT_W +: CNT_W] + 16'h0001;
			end
		end
		press = st_r.stable & ~st_r.prev; // R12
		st_nxt.highV  = ~st_r.voltS2; // R8
		st_nxt.bootOk = (st_r.bootS2 == BOOT_SINGLE_CHIP); // R9
		if (st_r.rstCnt != CNT_ZERO) begin
			st_nxt.rstCnt = st_r.rstCnt - 16'h0001;
		end
		st_nxt.cpuRst = (st_r.rstCnt != CNT_ZERO);

		case (st_r.state)
			ST_INIT: begin
				if (st_r.initCnt == CNT_W'(INIT_CYCLES - 1)) begin
					st_nxt.state = ST_IDLE; // R1
				end else begin
					st_nxt.initCnt = st_r.initCnt + 16'h0001;
				end
			end
			ST_IDLE: begin
				// toggling only honoured with both stages off
				if (press[2]) begin
					st_nxt.freq = ~st_r.freq; // R5 R7
				end
				if (press[0] && !press[1]) begin
					st_nxt.state = ST_SOFT; // R2 R12
				end
			end
			ST_SOFT: begin
				if (press[1]) begin
					st_nxt.state = ST_IDLE; // R4
				end else if (st_r.doneS2[0]) begin
					st_nxt.state = ST_INV_UP; // R11
				end
			end
			ST_INV_UP: begin
				if (press[1]) begin
					st_nxt.state = ST_IDLE; // R4
				end else if (st_r.doneS2[1]) begin
					st_nxt.state = ST_RUN; // R3
				end
			end
			ST_RUN: begin
				if (press[1]) begin
					st_nxt.state = ST_IDLE; // R4
				end
			end
			default: st_nxt.state = ST_INIT;
		endcase

		// reset button restarts everything and pulses the processor reset
		if (press[3]) begin
			st_nxt.state   = ST_INIT; // R10
			st_nxt.initCnt = CNT_ZERO;
			st_nxt.freq    = FREQ_RESET; // R6
			st_nxt.rstCnt  = CNT_W'(CPU_RESET_CYCLES);
		end
		st_nxt.boostEn = (st_nxt.state == ST_SOFT) || (st_nxt.state == ST_INV_UP)
			|| (st_nxt.state == ST_RUN); // R2
		st_nxt.invEn = (st_nxt.state == ST_INV_UP) || (st_nxt.state == ST_RUN); // R11
		st_nxt.run   = (st_nxt.state == ST_RUN); // R3
		st_nxt.idl   = (st_nxt.state == ST_IDLE);
	end

	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r       <= '0;
			st_r.state <= ST_INIT; // R1
			st_r.freq  <= FREQ_RESET; // R6
			st_r.highV <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign boostEnable    = st_r.boostEn;
	assign inverterEnable = st_r.invEn;
	assign running        = st_r.run;
	assign idle           = st_r.idl;
	assign freqSelect60   = st_r.freq;
	assign highVoltageSel = st_r.highV;
	assign cpuResetOut    = st_r.cpuRst;
	assign bootModeOk     = st_r.bootOk;

	//--------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_inv_after_boost: assert property (inverterEnable |-> boostEnable) // R11
		else $error("inverter enabled without boost");
	a_run_needs_inv: assert property (running |-> inverterEnable) // R3
		else $error("running without inverter");
	a_soft_holds_inv: assert property (st_r.state == ST_SOFT |-> !st_r.invEn) // R11
		else $error("inverter on during soft start");
	a_start_boost: assert property (st_r.state == ST_IDLE && press[0] && !press[1] && !press[3]
		|=> boostEnable && !inverterEnable) // R2
		else $error("start did not enable boost alone");
	a_stop_halts: assert property (st_r.state != ST_INIT && press[1] && !press[3]
		|=> !boostEnable && !inverterEnable && idle) // R4
		else $error("stop did not halt stages");
	a_freq_flip: assert property (st_r.state == ST_IDLE && press[2] && !press[3]
		|=> freqSelect60 != $past(freqSelect60)) // R5
		else $error("frequency did not flip");
	a_freq_locked: assert property (boostEnable && !press[3] |=> $stable(freqSelect60)) // R7
		else $error("frequency changed while driven");
	// three stages from pin to output, so the history must be three deep before comparing
	a_volt_map: assert property (##3 1 |-> highVoltageSel == !$past(voltageRangeDip, 3)) // R8
		else $error("voltage select mismatch");
	a_boot_map: assert property (##3 1
		|-> bootModeOk == ($past(cpuBootModeDip, 3) == BOOT_SINGLE_CHIP)) // R9
		else $error("boot mode check wrong");
	// reset pulse starts one cycle after the controller itself is back in init
	a_reset_btn: assert property (press[3] |=> st_r.state == ST_INIT ##1 cpuResetOut
		&& freqSelect60) // R10
		else $error("reset button ignored");
	a_init_idle: assert property (st_r.state == ST_INIT
		&& st_r.initCnt == CNT_W'(INIT_CYCLES - 1) && !press[3]
		|=> idle) // R1
		else $error("init did not reach idle");
	a_one_event: assert property (press[0] |=> !press[0]) // R12
		else $error("press lasted more than one cycle");
	a_debounce_len: assert property ($changed(st_r.stable[0])
		|-> $past(st_r.dbCnt[CNT_W-1:0]) == CNT_W'(DEBOUNCE_CYCLES - 1)) // R12
		else $error("start level accepted before debounce window");

	//--------------------------------------------------------------
	// covers
	//--------------------------------------------------------------
	c_start_run: cover property (st_r.state == ST_INV_UP ##1 running);
	c_stop_run: cover property (running ##1 idle);
	c_freq_toggle: cover property (press[2] && idle);
	c_reset_press: cover property (press[3]);

endmodule : converter_startup_control

// ==== design/startup_pkg.sv ====
// constants and types for the converter start/stop sequencer
package startup_pkg;

	// debounce: button must hold steady this long
	localparam int DEBOUNCE_US     = 10;
	localparam int CLOCK_MHZ       = 40;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLOCK_MHZ;
	// initialisation time after power-on / reset
	localparam int INIT_US         = 20;
	localparam int INIT_CYCLES     = INIT_US * CLOCK_MHZ;
	// reset-button pulse width to the processor
	localparam int CPU_RESET_US    = 5;
	localparam int CPU_RESET_CYCLES = CPU_RESET_US * CLOCK_MHZ;
	localparam int CNT_W           = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	// frequency select encoding and startup value
	localparam logic FREQ_50HZ     = 1'b0;
	localparam logic FREQ_60HZ     = 1'b1;
	localparam logic FREQ_RESET    = FREQ_60HZ;
	// boot-mode DIP setting for single-chip operation (1=on, bit0 = position 1)
	localparam logic [2:0] BOOT_SINGLE_CHIP = 3'h1;

	typedef enum logic [4:0] {
		ST_INIT    = 5'h01,
		ST_IDLE    = 5'h02,
		ST_SOFT    = 5'h04,
		ST_INV_UP  = 5'h08,
		ST_RUN     = 5'h10
	} seq_state_e;

endpackage : startup_pkg

// ==== test/operator_panel.sv ====
// operator push buttons seen from the sequencer's pins
`timescale 1ns/100ps
module operator_panel (
	output logic [3:0] buttons
);
	initial buttons = 4'h0;
	// hold well past the 400-cycle debounce so each press is one clean event
	task automatic press(input logic [3:0] mask);
		buttons = mask;
		#11250ns buttons = 4'h0;
	endtask : press
endmodule : operator_panel

// ==== test/converter_startup_control_test.sv ====
// self-checking bench for the converter start/stop sequencer
`timescale 1ns/100ps
module converter_startup_control_test import startup_pkg::*;;
	logic       clock, rst, softDone, invDone, voltDip;
	logic [2:0] bootDip;
	logic [3:0] buttons;
	logic       boostEn, invEn, running, idle, freq60, highV, cpuRst, bootOk;
	int         failures = 0;
	int         tests_run = 0;

	operator_panel u_operator_panel (.buttons(buttons));
	converter_startup_control u_converter_startup_control (
		.clock(clock), .rst(rst),
		.runRequestButton(buttons[0]), .haltRequestButton(buttons[1]),
		.freqToggleButton(buttons[2]), .cpuResetButton(buttons[3]),
		.voltageRangeDip(voltDip), .cpuBootModeDip(bootDip),
		.softStartDone(softDone), .inverterStartDone(invDone),
		.boostEnable(boostEn), .inverterEnable(invEn), .running(running),
		.idle(idle), .freqSelect60(freq60), .highVoltageSel(highV),
		.cpuResetOut(cpuRst), .bootModeOk(bootOk)
	);

	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	// release debounce must pass before the next press is seen
	task automatic act(input logic [3:0] mask);
		cyc(450);
		u_operator_panel.press(mask);
	endtask : act
	function automatic logic [7:0] st();
		return {4'h0, boostEn, invEn, running, idle};
	endfunction : st
	task automatic report_and_stop();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// --------------------------------------------------
	// stimulus
	// --------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #12.5ns clock = ~clock;
	end
	initial begin
		cyc(20000);
		failures++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		softDone = 1'b0;
		invDone = 1'b0;
		voltDip = 1'b0;
		bootDip = BOOT_SINGLE_CHIP;
		cyc(5);
		rst = 1'b0;
		cyc(810);
		check(st(), 8'h01);
		check({7'h0, freq60}, 8'h01);
		check({7'h0, highV}, 8'h01);
		check({7'h0, bootOk}, 8'h01);
		bootDip = 3'h3;
		voltDip = 1'b1;
		cyc(5);
		check({7'h0, bootOk}, 8'h00);
		check({7'h0, highV}, 8'h00);
		act(4'h4);
		check({7'h0, freq60}, 8'h00);
		act(4'h4);
		check({7'h0, freq60}, 8'h01);
		act(4'h3);
		check(st(), 8'h01);
		act(4'h1);
		check(st(), 8'h08);
		act(4'h4);
		check({7'h0, freq60}, 8'h01);
		softDone = 1'b1;
		cyc(5);
		check(st(), 8'h0c);
		invDone = 1'b1;
		cyc(5);
		check(st(), 8'h0e);
		act(4'h2);
		check(st(), 8'h01);
		softDone = 1'b0;
		invDone = 1'b0;
		act(4'h4);
		check({7'h0, freq60}, 8'h00);
		act(4'h1);
		check(st(), 8'h08);
		act(4'h8);
		check(st(), 8'h00);
		check({7'h0, cpuRst}, 8'h01);
		check({7'h0, freq60}, 8'h01);
		cyc(1000);
		check(st(), 8'h01);
		check({7'h0, cpuRst}, 8'h00);
		report_and_stop();
	end
endmodule : converter_startup_control_test
